// file: logic/modbus_single_register_write.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Function 06 writes one 16-bit control register
// RULE_02: Broadcast address writes own register too
// RULE_03: Master uses axis plus one, or 00
// RULE_04: Four registers at 0D00, 0D01, 0D03, 9800
// RULE_05: Link writes only in link-command mode
// RULE_06: Parallel mode maps registers from input ports
// RULE_07: Master sends data as four hex characters
// RULE_08: Frame is seventeen characters in fixed fields
// RULE_09: LRC check field validates every frame
// RULE_10: Good write echoes the query unchanged
// RULE_11: Invalid data: no reply, register unchanged
// RULE_12: Writing 1000 to control one sets servo on
// RULE_13: Writing 1010 requests home keeping servo on
// RULE_14: Home request ignored while servo is off
// RULE_15: Master resends unchanged bits every write
// RULE_16: Master keeps servo-on bit set
// RULE_17: Master homes before position movement command
// RULE_18: Position movement write starts motion immediately
// RULE_19: Frames open with 3A, close with 0D0A
// RULE_20: Broadcast write performs write, sends no reply
module modbus_single_register_write #(
  parameter logic [7:0] AXIS_NUMBER = 8'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic link_vs_parallel_io_select,
  input wire logic [15:0] parallel_io_control_one,
  input wire logic [15:0] parallel_io_control_two,
  input wire logic [15:0] parallel_io_position,
  output logic [7:0] tx_char,
  output logic tx_valid,
  output logic [15:0] device_control_one,
  output logic [15:0] device_control_two,
  output logic [15:0] position_number_select,
  output logic [15:0] position_movement_command,
  output logic home_request,
  output logic move_start
);

  typedef enum {st_idle, st_recv, st_check, st_echo} state_t;

  // Hex character to nibble; flags non-hex characters
  function automatic logic [4:0] hex_nibble(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hex_nibble = {1'b1, 4'(c - 8'h30)};
    else if (c >= 8'h41 && c <= 8'h46) hex_nibble = {1'b1, 4'(c - 8'h37)};
    else hex_nibble = 5'h00;
  endfunction : hex_nibble

  state_t state_ff, nxt_state;
  logic [7:0] frame_ff [single_write_pkg::FRAME_CHARS];
  logic [7:0] nxt_frame [single_write_pkg::FRAME_CHARS];
  logic [4:0] count_ff, nxt_count;
  logic [15:0] ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2;
  logic [15:0] posn_ff, nxt_posn, move_ff, nxt_move;
  logic [7:0] tx_char_ff, nxt_tx_char;
  logic tx_valid_ff, nxt_tx_valid, home_ff, nxt_home, start_ff, nxt_start;
  logic [7:0] bytes [single_write_pkg::FRAME_BYTES];
  logic hex_ok;
  logic [7:0] lrc_sum;
  logic [15:0] reg_addr, reg_data;
  logic addr_ok, is_bcast, frame_ok, reg_known;

  // Decode the fourteen hex characters into seven bytes
  always_comb begin
    logic [4:0] hi;
    logic [4:0] lo;
    hi = 5'h00;
    lo = 5'h00;
    hex_ok = 1'b1;
    for (int i = 0; i < single_write_pkg::FRAME_BYTES; i++) begin
      hi = hex_nibble(frame_ff[1 + 2 * i]);
      lo = hex_nibble(frame_ff[2 + 2 * i]);
      bytes[i] = {hi[3:0], lo[3:0]};
      hex_ok = hex_ok & hi[4] & lo[4];
    end
  end

  // LRC: sum of all bytes including check must be zero
  always_comb begin
    lrc_sum = 8'h00;
    for (int i = 0; i < single_write_pkg::FRAME_BYTES; i++) begin
      lrc_sum = 8'(lrc_sum + bytes[i]); // RULE_09
    end
  end

  // Frame field checks
  always_comb begin
    reg_addr = {bytes[2], bytes[3]};
    reg_data = {bytes[4], bytes[5]};
    is_bcast = bytes[0] == single_write_pkg::ADDR_BROADCAST; // RULE_02
    addr_ok = is_bcast || (bytes[0] == 8'(AXIS_NUMBER + 8'h01));
    reg_known = reg_addr == single_write_pkg::REG_DEVICE_CONTROL_ONE ||
                reg_addr == single_write_pkg::REG_DEVICE_CONTROL_TWO ||
                reg_addr == single_write_pkg::REG_POSITION_NUMBER ||
                reg_addr == single_write_pkg::REG_POSITION_MOVEMENT; // RULE_04
    frame_ok = hex_ok && lrc_sum == 8'h00 && addr_ok &&
               frame_ff[0] == single_write_pkg::CHAR_HEADER &&
               frame_ff[15] == single_write_pkg::CHAR_CR &&
               frame_ff[16] == single_write_pkg::CHAR_LF; // RULE_19
  end

  // Frame receive, check, write and echo sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_frame = frame_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_posn = posn_ff;
    nxt_move = move_ff;
    nxt_tx_char = tx_char_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_home = 1'b0;
    nxt_start = 1'b0;
    case (state_ff)
      st_idle: begin
        if (rx_valid && rx_char == single_write_pkg::CHAR_HEADER) begin // RULE_19
          nxt_frame[0] = rx_char;
          nxt_count = 5'd1;
          nxt_state = st_recv;
        end
      end
      st_recv: begin
        if (rx_valid) begin
          if (rx_char == single_write_pkg::CHAR_HEADER) begin
            nxt_count = 5'd1; // Restart on a fresh header
          end else begin
            nxt_frame[count_ff] = rx_char;
            nxt_count = 5'(count_ff + 5'd1);
            if (count_ff == 5'(single_write_pkg::FRAME_CHARS - 1)) begin // RULE_08
              nxt_state = st_check;
            end
          end
        end
      end
      st_check: begin
        nxt_state = st_idle;
        // Bad frames, other functions and unknown registers get no reply
        if (frame_ok && bytes[1] == single_write_pkg::FUNC_WRITE_SINGLE && reg_known &&
            !link_vs_parallel_io_select) begin // RULE_01 RULE_05 RULE_11
          case (reg_addr)
            single_write_pkg::REG_DEVICE_CONTROL_ONE: begin
              nxt_ctrl1 = reg_data; // RULE_12 RULE_13
              nxt_home = reg_data[single_write_pkg::HOME_BIT] &&
                         !ctrl1_ff[single_write_pkg::HOME_BIT] &&
                         ctrl1_ff[single_write_pkg::SERVO_ON_BIT] &&
                         reg_data[single_write_pkg::SERVO_ON_BIT]; // RULE_14
            end
            single_write_pkg::REG_DEVICE_CONTROL_TWO: nxt_ctrl2 = reg_data;
            single_write_pkg::REG_POSITION_NUMBER: nxt_posn = reg_data;
            default: begin
              nxt_move = reg_data;
              nxt_start = 1'b1; // RULE_18
            end
          endcase
          if (!is_bcast) begin // RULE_20
            nxt_count = 5'd0;
            nxt_state = st_echo; // RULE_10
          end
        end
      end
      st_echo: begin
        if (!tx_valid_ff || tx_ready) begin
          if (count_ff == 5'(single_write_pkg::FRAME_CHARS)) begin
            nxt_tx_valid = 1'b0;
            nxt_state = st_idle;
          end else begin
            nxt_tx_char = frame_ff[count_ff];
            nxt_tx_valid = 1'b1;
            nxt_count = 5'(count_ff + 5'd1);
          end
        end
      end
      default: nxt_state = st_idle;
    endcase
    // Parallel mode drives registers from input ports
    if (link_vs_parallel_io_select) begin // RULE_06
      nxt_home = parallel_io_control_one[single_write_pkg::HOME_BIT] &&
                 !ctrl1_ff[single_write_pkg::HOME_BIT] &&
                 ctrl1_ff[single_write_pkg::SERVO_ON_BIT] &&
                 parallel_io_control_one[single_write_pkg::SERVO_ON_BIT]; // RULE_14
      nxt_ctrl1 = parallel_io_control_one;
      nxt_ctrl2 = parallel_io_control_two;
      nxt_posn = parallel_io_position;
    end
  end

  // State registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= st_idle;
      count_ff <= 5'd0;
      for (int i = 0; i < single_write_pkg::FRAME_CHARS; i++) frame_ff[i] <= 8'h00;
      ctrl1_ff <= single_write_pkg::REG_RESET;
      ctrl2_ff <= single_write_pkg::REG_RESET;
      posn_ff <= single_write_pkg::REG_RESET;
      move_ff <= single_write_pkg::REG_RESET;
      tx_char_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      home_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      frame_ff <= nxt_frame;
      ctrl1_ff <= nxt_ctrl1;
      ctrl2_ff <= nxt_ctrl2;
      posn_ff <= nxt_posn;
      move_ff <= nxt_move;
      tx_char_ff <= nxt_tx_char;
      tx_valid_ff <= nxt_tx_valid;
      home_ff <= nxt_home;
      start_ff <= nxt_start;
    end
  end

  // Outputs straight from flip-flops
  assign tx_char = tx_char_ff;
  assign tx_valid = tx_valid_ff;
  assign device_control_one = ctrl1_ff;
  assign device_control_two = ctrl2_ff;
  assign position_number_select = posn_ff;
  assign position_movement_command = move_ff;
  assign home_request = home_ff;
  assign move_start = start_ff;

endmodule : modbus_single_register_write

// file: logic/single_write_pkg.sv
package single_write_pkg;
  // Frame characters
  localparam logic [7:0] CHAR_HEADER = 8'h3A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam int FRAME_CHARS = 17;
  // Field values
  localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'h10;
  // Register addresses
  localparam logic [15:0] REG_DEVICE_CONTROL_ONE = 16'h0D00;
  localparam logic [15:0] REG_DEVICE_CONTROL_TWO = 16'h0D01;
  localparam logic [15:0] REG_POSITION_NUMBER = 16'h0D03;
  localparam logic [15:0] REG_POSITION_MOVEMENT = 16'h9800;
  // Reset values and field positions
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int SERVO_ON_BIT = 12;
  localparam int HOME_BIT = 4;
  // Decoded frame bytes: addr, func, reg hi, reg lo, data hi, data lo, lrc
  localparam int FRAME_BYTES = 7;
endpackage : single_write_pkg

// file: test/modbus_write_sva.sv
`timescale 1ns/1ps
// Frame, echo and pulse relations at the ports
module modbus_write_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  input wire logic [15:0] device_control_one,
  input wire logic [15:0] position_movement_command,
  input wire logic home_request,
  input wire logic move_start
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_move_reg_quiet: assert property (
    !$past(rx_valid) && !$past(rx_valid, 2) && !$past(rx_valid, 3) |-> $stable(position_movement_command))
    else $error("move reg changed");
  a_home_needs_servo: assert property (home_request |-> ($past(device_control_one) & 16'h1010) == 16'h1000
    && (device_control_one & 16'h1010) == 16'h1010) else $error("bad home pulse");
  a_move_one_pulse: assert property (move_start |=> !move_start) else $error("long move pulse");
  a_move_after_lf: assert property (
    move_start |-> $past(rx_valid, 2) && $past(rx_char, 2) == 8'h0A) else $error("move pulse timing");
  a_echo_char_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_char)) else $error("echo dropped");
  a_echo_starts_hdr: assert property ($rose(tx_valid) |-> tx_char == 8'h3A) else $error("echo header");
  a_echo_after_lf: assert property (
    $rose(tx_valid) |-> $past(rx_valid, 3) && $past(rx_char, 3) == 8'h0A) else $error("echo timing");
  a_echo_ends_lf: assert property (
    tx_valid && tx_ready && tx_char == 8'h0A |=> !tx_valid) else $error("echo too long");
endmodule : modbus_write_sva
bind modbus_single_register_write modbus_write_sva i_modbus_write_sva (.clock, .rst, .rx_char, .rx_valid,
  .tx_ready, .tx_char, .tx_valid, .device_control_one, .position_movement_command, .home_request, .move_start);

// file: test/host_model.sv
`timescale 1ns/1ps
// Host master: sends ASCII query frames and takes the echo
module host_model (
  input wire logic clock,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  output logic [7:0] rx_char,
  output logic rx_valid,
  output logic tx_ready
);
  logic [7:0] q [17];
  logic [7:0] echo [17];
  logic slow = 1'b0;
  int n_echo = 0;
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : hx
  // Builds one frame, optionally with a broken check byte, then sends a char per cycle
  task automatic send(input logic [7:0] sa, fc, input logic [15:0] ra, d, input logic bad);
    logic [7:0] b [7];
    b = '{sa, fc, ra[15:8], ra[7:0], d[15:8], d[7:0], 8'h00};
    b[6] = 8'h00 - (sa + fc + ra[15:8] + ra[7:0] + d[15:8] + d[7:0]) + {7'h00, bad};
    q[0] = 8'h3A;
    for (int i = 0; i < 7; i++) begin
      q[2 * i + 1] = hx(b[i][7:4]);
      q[2 * i + 2] = hx(b[i][3:0]);
    end
    q[15] = 8'h0D;
    q[16] = 8'h0A;
    n_echo = 0;
    for (int i = 0; i < 17; i++) begin
      @(posedge clock);
      rx_char <= q[i];
      rx_valid <= 1'b1;
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_char <= ~q[16];
  endtask : send
  // Takes echo chars; stalls every other cycle when slow
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && n_echo < 17) begin
      echo[n_echo] <= tx_char;
      n_echo <= n_echo + 1;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  initial begin
    rx_char = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
endmodule : host_model

// file: test/modbus_single_register_write_tb.sv
`timescale 1ns/1ps
module modbus_single_register_write_tb;
  logic clock, rst, rx_valid, tx_ready, tx_valid, home_request, move_start;
  logic link_vs_parallel_io_select = 1'b0;
  logic [7:0] rx_char, tx_char;
  logic [15:0] parallel_io_control_one = 16'h0000, parallel_io_control_two = 16'h0000;
  logic [15:0] parallel_io_position = 16'h0000, device_control_one, device_control_two;
  logic [15:0] position_number_select, position_movement_command;
  int n_mismatch = 0, n_tests = 0, n_home = 0, n_move = 0;
  modbus_single_register_write i_modbus_single_register_write (.clock, .rst, .rx_char, .rx_valid, .tx_ready,
    .link_vs_parallel_io_select, .parallel_io_control_one, .parallel_io_control_two, .parallel_io_position,
    .tx_char, .tx_valid, .device_control_one, .device_control_two, .position_number_select,
    .position_movement_command, .home_request, .move_start);
  host_model i_host_model (.clock, .tx_char, .tx_valid, .rx_char, .rx_valid, .tx_ready);
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Pulse counters
  always @(posedge clock) begin
    if (home_request === 1'b1) n_home++;
    if (move_start === 1'b1) n_move++;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk_reg(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_cnt(input int got, exp);
    n_tests++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: count %0d, want %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // One query; waits for the echo when due and compares it with the query
  task automatic run(input logic [7:0] sa, fc, input logic [15:0] ra, d, input logic bad, input int want);
    int k;
    i_host_model.send(sa, fc, ra, d, bad);
    for (k = 0; k < 100 && !(want == 17 && i_host_model.n_echo == 17); k++) begin
      @(posedge clock);
      #1;
    end
    if (k == 100 && want == 17 && i_host_model.n_echo != 17) begin
      n_mismatch++;
      end_of_test();
    end
    chk_cnt(i_host_model.n_echo, want);
    for (int i = 0; i < want; i++) chk_reg({8'h00, i_host_model.echo[i]}, {8'h00, i_host_model.q[i]});
  endtask : run
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_reg(device_control_one | position_movement_command, 16'h0000);
    run(8'h01, 8'h06, 16'h0D00, 16'h1010, 1'b0, 17);
    chk_cnt(n_home, 0);
    i_host_model.slow = 1'b1;
    run(8'h01, 8'h06, 16'h0D00, 16'h1000, 1'b0, 17);
    chk_reg(device_control_one, 16'h1000);
    run(8'h01, 8'h06, 16'h0D00, 16'h1010, 1'b0, 17);
    chk_cnt(n_home, 1);
    run(8'h01, 8'h06, 16'h9800, 16'h0001, 1'b0, 17);
    chk_cnt(n_move, 1);
    run(8'h00, 8'h06, 16'h0D01, 16'h1234, 1'b0, 0);
    run(8'h00, 8'h06, 16'h0D03, 16'h0005, 1'b0, 0);
    chk_reg(position_number_select, 16'h0005);
    run(8'h05, 8'h06, 16'h0D01, 16'hFFFF, 1'b0, 0);
    run(8'h01, 8'h03, 16'h0D01, 16'hFFFF, 1'b0, 0);
    run(8'h01, 8'h06, 16'h0D02, 16'hFFFF, 1'b0, 0);
    run(8'h01, 8'h06, 16'h0D01, 16'hFFFF, 1'b1, 0);
    chk_reg(device_control_two, 16'h1234);
    // Parallel mode: registers follow ports, link writes refused
    @(posedge clock);
    link_vs_parallel_io_select <= 1'b1;
    parallel_io_control_one <= 16'h1000;
    parallel_io_control_two <= 16'hA5A5;
    parallel_io_position <= 16'h0007;
    run(8'h01, 8'h06, 16'h9800, 16'h0002, 1'b0, 0);
    chk_reg(device_control_two ^ position_number_select, 16'hA5A2);
    chk_reg(position_movement_command, 16'h0001);
    chk_reg(device_control_one, 16'h1000);
    // Home bit rising on the port with servo held on gives one pulse
    @(posedge clock);
    parallel_io_control_one <= 16'h1010;
    repeat (2) @(posedge clock);
    #1;
    chk_cnt(n_home, 2);
    end_of_test();
  end
endmodule : modbus_single_register_write_tb
